// ==== logic/rss_pkg.sv ====
package rss_pkg;

	// Brown-out mode configuration encodings
	localparam logic [1:0] BOR_MODE_OFF   = 2'h0;
	localparam logic [1:0] BOR_MODE_SW    = 2'h1;
	localparam logic [1:0] BOR_MODE_NOSLP = 2'h2;
	localparam logic [1:0] BOR_MODE_ON    = 2'h3;

	// Register addresses on the plain port
	localparam logic [3:0] ADDR_BOR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_PWR_CTRL = 4'h1;
	localparam logic [3:0] ADDR_STATUS   = 4'h2;

	// Brown-out control register fields
	localparam int BC_SW_EN = 7;
	localparam int BC_RDY   = 0;
	// Spare control bit drives the pin pull-up while pin reset is off
	localparam int BC_PULLUP = 6;

	// Power control register fields
	localparam int PC_STACK_OVERFLOW_FLAG = 7;
	localparam int PC_STACK_UNDERFLOW_FLAG = 6;
	localparam int PC_WDT_N  = 4;
	localparam int PC_PIN_N  = 3;
	localparam int PC_RI_N   = 2;
	localparam int PC_POR_N  = 1;
	localparam int PC_BOR_N  = 0;

	// Status register fields
	localparam int ST_TO_N = 1;
	localparam int ST_PD_N = 0;

	// Reset values
	localparam logic [7:0] PC_RESET = 8'h1c;
	localparam logic [7:0] BC_RESET = 8'h80;
	localparam logic [1:0] ST_RESET = 2'h3;

	// Timing, clock 25 MHz
	localparam int CLK_HZ         = 25000000;
	localparam int POWERUP_TIMER_MS        = 64;
	localparam int POWERUP_TIMER_CYCLES    = POWERUP_TIMER_MS * (CLK_HZ / 1000);
	localparam int DEBOUNCE_NS    = 1000;
	localparam int DEBOUNCE_CYC   = (DEBOUNCE_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam int PIN_FILT_NS    = 200;
	localparam int PIN_FILT_CYC   = (PIN_FILT_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam int START_OSC_CYC  = 10;
	localparam int CNT_W          = 24;

	typedef enum logic [3:0]
	{
		SEQ_HOLD  = 4'h1,
		SEQ_POWERUP_TIMER  = 4'h2,
		SEQ_WAIT  = 4'h4,
		SEQ_RUN   = 4'h8
	} rss_seq_t;

endpackage

// ==== logic/rss_reset_source_sequencer.sv ====
`timescale 1ns/1ps
// Function
// - Mode 11 keeps brown-out always on; start-up waits for ready and good supply.
// - Mode 11 protects during sleep and adds no brown-out delay to wake.
// - Mode 10 disables detection in sleep; start and wake wait ready/supply.
// - Mode 01 uses software enable; wake skips delay if clear and non-brown-out start.
// - Software mode protects once ready and reports readiness in ready flag.
// - Mode 00 disables detection; software enable ignored.
// - Brown-out resets and clears flag only after dip longer than debounce time.
// - Mode 00 or 01 with enable clear starts execution without waiting ready.
// - Low-power detector holds reset and ORs into combined brown-out flag.
// - In mode 10 low-power detector holds reset and re-arms power-on reset.
// - Low-power detector has its own enable, independent of main detector.
// - Reset pin enabled when low-voltage programming or pin enable is set.
// - Enabled reset pin low holds reset, with short pulses filtered out.
// - The device never drives the reset pin low.
// - Disabled reset pin is a general input with software pull-up.
// - Watchdog timeout resets and updates timeout, powerdown and watchdog flags.
// - Reset instruction resets and clears active-low reset-instruction flag.
// - With stack reset enabled, overflow or underflow resets and sets its flag.
// - Leaving programming mode acts as a device reset.
// - Power-up timer, enabled by low bit, holds 64 ms after power or brown-out.
// - Execution waits for power-up timer, reset pin and oscillator timer.
// - Pin hold aborts the power-up timer to the wait state; execution starts 10 wait cycles after the filtered pin release.
// - Outside software mode the software enable stays read/write without effect.
module rss_reset_source_sequencer
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       clk_en,
	input  wire logic [1:0] brownout_mode_cfg,
	input  wire logic       low_power_brownout_en,
	input  wire logic       ext_reset_pin_enable,
	input  wire logic       low_voltage_prog,
	input  wire logic       powerup_timer_enable_n,
	input  wire logic       stack_reset_enable,
	input  wire logic       osc_startup_needed,
	input  wire logic       osc_startup_done,
	input  wire logic       por_active,
	input  wire logic       vdd_below_bor,
	input  wire logic       vdd_below_low_power_brownout,
	input  wire logic       bor_circuit_ready,
	input  wire logic       ext_reset_pin_in,
	input  wire logic       sleep_req,
	input  wire logic       wake_event,
	input  wire logic       watchdog_timeout,
	input  wire logic       watchdog_clear_instr,
	input  wire logic       reset_instr,
	input  wire logic       stack_overflow,
	input  wire logic       stack_underflow,
	input  wire logic       prog_mode_exit,
	input  wire logic [3:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	output logic            core_reset_n,
	output logic            cpu_run,
	output logic            in_sleep,
	output logic            bor_detect_on,
	output logic            ext_reset_pin_out,
	output logic            ext_reset_pin_oe_n,
	output logic            ext_reset_pin_pullup,
	output logic            gpio_in
);

	rss_pkg::rss_seq_t seq_q;
	logic [rss_pkg::CNT_W-1:0] cnt_q;
	logic [7:0] dbc_q;
	logic [7:0] pin_filt_q;
	logic       pin_low_q;
	logic [7:0] pcon_q;
	logic [7:0] bcon_q;
	logic [1:0] stat_q;
	logic       sleep_q;
	logic       wake_skip_q;
	logic       por_boot_q;
	logic       pin_en;
	logic       det_on;
	logic       bor_trip;
	logic       lp_trip;
	logic       bor_event;
	logic       sync_reset;
	logic       need_ready;

	function automatic logic bor_active(input logic [1:0] mode, input logic sw_en, input logic slp);
		case (mode)
			rss_pkg::BOR_MODE_ON:    bor_active = 1'b1;
			rss_pkg::BOR_MODE_NOSLP: bor_active = !slp;
			rss_pkg::BOR_MODE_SW:    bor_active = sw_en;
			default:                 bor_active = 1'b0;
		endcase
	endfunction

	assign pin_en     = ext_reset_pin_enable || low_voltage_prog;
	assign det_on     = bor_active(brownout_mode_cfg, bcon_q[rss_pkg::BC_SW_EN], sleep_q);
	assign bor_trip   = det_on && bor_circuit_ready &&
		(dbc_q == 8'(rss_pkg::DEBOUNCE_CYC));
	assign lp_trip    = low_power_brownout_en && vdd_below_low_power_brownout;
	assign bor_event  = bor_trip || lp_trip;
	assign sync_reset = watchdog_timeout || reset_instr || prog_mode_exit ||
		(stack_reset_enable && (stack_overflow || stack_underflow)) ||
		(pin_en && pin_low_q);
	// Ready/supply wait applies unless the mode leaves the detector off
	assign need_ready = (brownout_mode_cfg == rss_pkg::BOR_MODE_ON) ||
		(brownout_mode_cfg == rss_pkg::BOR_MODE_NOSLP) ||
		((brownout_mode_cfg == rss_pkg::BOR_MODE_SW) && bcon_q[rss_pkg::BC_SW_EN]);

	// Supply dip debounce: short dips never reach the debounce count
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			dbc_q <= 8'h00;
		else if (clk_en)
		begin
			if (!(det_on && vdd_below_bor))
				dbc_q <= 8'h00;
			else if (dbc_q != 8'(rss_pkg::DEBOUNCE_CYC))
				dbc_q <= dbc_q + 8'h01;
		end
	end

	// Reset pin noise filter
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_filt_q <= 8'h00;
			pin_low_q  <= 1'b0;
		end
		else if (clk_en)
		begin
			if (ext_reset_pin_in == pin_low_q)
			begin
				if (pin_filt_q == 8'(rss_pkg::PIN_FILT_CYC))
				begin
					pin_low_q  <= !ext_reset_pin_in;
					pin_filt_q <= 8'h00;
				end
				else
					pin_filt_q <= pin_filt_q + 8'h01;
			end
			else
				pin_filt_q <= 8'h00;
		end
	end

	// Sleep tracking
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			sleep_q <= 1'b0;
		else if (clk_en)
		begin
			if (seq_q != rss_pkg::SEQ_RUN || wake_event)
				sleep_q <= 1'b0;
			else if (sleep_req)
				sleep_q <= 1'b1;
		end
	end

	// Start-up sequencer
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			seq_q      <= rss_pkg::SEQ_HOLD;
			cnt_q      <= '0;
			por_boot_q <= 1'b1;
			wake_skip_q <= 1'b0;
		end
		else if (clk_en)
		begin
			if (por_active || bor_event)
			begin
				seq_q      <= rss_pkg::SEQ_HOLD;
				cnt_q      <= '0;
				por_boot_q <= 1'b1;
			end
			else if (sync_reset)
			begin
				seq_q <= rss_pkg::SEQ_WAIT;
				cnt_q <= '0;
			end
			else
			begin
				case (seq_q)
					rss_pkg::SEQ_HOLD:
					begin
						cnt_q <= '0;
						if (!powerup_timer_enable_n)
							seq_q <= rss_pkg::SEQ_POWERUP_TIMER;
						else
							seq_q <= rss_pkg::SEQ_WAIT;
					end
					rss_pkg::SEQ_POWERUP_TIMER:
					begin
						// Not reached while the pin holds reset; sync reset moves to SEQ_WAIT
						if (cnt_q == rss_pkg::CNT_W'(rss_pkg::POWERUP_TIMER_CYCLES - 1))
						begin
							seq_q <= rss_pkg::SEQ_WAIT;
							cnt_q <= '0;
						end
						else
							cnt_q <= cnt_q + 1'b1;
					end
					rss_pkg::SEQ_WAIT:
					begin
						if ((osc_startup_done || !osc_startup_needed) &&
							(!need_ready || bor_circuit_ready))
						begin
							if (cnt_q == rss_pkg::CNT_W'(rss_pkg::START_OSC_CYC - 1))
							begin
								seq_q      <= rss_pkg::SEQ_RUN;
								por_boot_q <= 1'b0;
							end
							else
								cnt_q <= cnt_q + 1'b1;
						end
						else
							cnt_q <= '0;
					end
					rss_pkg::SEQ_RUN:
					begin
						wake_skip_q <= (brownout_mode_cfg == rss_pkg::BOR_MODE_SW) &&
							!bcon_q[rss_pkg::BC_SW_EN] && !por_boot_q;
						if (sleep_q && wake_event && brownout_mode_cfg == rss_pkg::BOR_MODE_NOSLP)
						begin
							seq_q <= rss_pkg::SEQ_WAIT;
							cnt_q <= rss_pkg::CNT_W'(rss_pkg::START_OSC_CYC - 1);
						end
					end
					default: seq_q <= rss_pkg::SEQ_HOLD;
				endcase
			end
		end
	end

	// Cause flags; hardware set wins over a same-cycle software write
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pcon_q <= rss_pkg::PC_RESET;
			bcon_q <= rss_pkg::BC_RESET;
			stat_q <= rss_pkg::ST_RESET;
		end
		else if (clk_en)
		begin
			if (reg_wr && reg_addr == rss_pkg::ADDR_PWR_CTRL)
				pcon_q <= reg_wdata;
			if (reg_wr && reg_addr == rss_pkg::ADDR_BOR_CTRL)
			begin
				bcon_q[rss_pkg::BC_SW_EN]  <= reg_wdata[rss_pkg::BC_SW_EN];
				bcon_q[rss_pkg::BC_PULLUP] <= reg_wdata[rss_pkg::BC_PULLUP];
			end
			bcon_q[rss_pkg::BC_RDY] <= det_on && bor_circuit_ready;
			if (por_active)
			begin
				pcon_q[rss_pkg::PC_POR_N] <= 1'b0;
				stat_q <= rss_pkg::ST_RESET;
			end
			if (bor_event)
				pcon_q[rss_pkg::PC_BOR_N] <= 1'b0;
			if (watchdog_timeout)
			begin
				pcon_q[rss_pkg::PC_WDT_N] <= 1'b0;
				stat_q[rss_pkg::ST_TO_N]  <= 1'b0;
				stat_q[rss_pkg::ST_PD_N]  <= !sleep_q;
			end
			else if (watchdog_clear_instr)
				stat_q <= rss_pkg::ST_RESET;
			else if (sleep_req && seq_q == rss_pkg::SEQ_RUN)
				stat_q <= 2'h2;
			if (reset_instr)
				pcon_q[rss_pkg::PC_RI_N] <= 1'b0;
			if (pin_en && pin_low_q)
				pcon_q[rss_pkg::PC_PIN_N] <= 1'b0;
			if (stack_reset_enable && stack_overflow)
				pcon_q[rss_pkg::PC_STACK_OVERFLOW_FLAG] <= 1'b1;
			if (stack_reset_enable && stack_underflow)
				pcon_q[rss_pkg::PC_STACK_UNDERFLOW_FLAG] <= 1'b1;
		end
	end

	// Register read, data one cycle after the strobe
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			reg_rdata <= 8'h00;
		else if (clk_en)
		begin
			if (!reg_rd)
				reg_rdata <= 8'h00;
			else
			begin
				case (reg_addr)
					rss_pkg::ADDR_BOR_CTRL: reg_rdata <= bcon_q;
					rss_pkg::ADDR_PWR_CTRL: reg_rdata <= pcon_q;
					rss_pkg::ADDR_STATUS:   reg_rdata <= {6'h00, stat_q};
					default:                reg_rdata <= 8'h00;
				endcase
			end
		end
	end

	// Outputs, all registered
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			core_reset_n         <= 1'b0;
			cpu_run              <= 1'b0;
			in_sleep             <= 1'b0;
			bor_detect_on        <= 1'b0;
			ext_reset_pin_out    <= 1'b0;
			ext_reset_pin_oe_n   <= 1'b1;
			ext_reset_pin_pullup <= 1'b1;
			gpio_in              <= 1'b0;
		end
		else if (clk_en)
		begin
			core_reset_n         <= seq_q == rss_pkg::SEQ_RUN;
			cpu_run              <= seq_q == rss_pkg::SEQ_RUN && (!sleep_q || wake_skip_q || !need_ready ||
				brownout_mode_cfg == rss_pkg::BOR_MODE_ON);
			in_sleep             <= sleep_q;
			bor_detect_on        <= det_on;
			ext_reset_pin_out    <= 1'b0;
			ext_reset_pin_oe_n   <= 1'b1;
			ext_reset_pin_pullup <= pin_en ? 1'b1 : bcon_q[rss_pkg::BC_PULLUP];
			gpio_in              <= pin_en ? 1'b0 : ext_reset_pin_in;
		end
	end

endmodule

// ==== verification/rss_reset_source_sequencer_sva.sv ====
`timescale 1ns/1ps
module rss_checker
(
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic [1:0] brownout_mode_cfg,
	input wire logic       ext_reset_pin_enable,
	input wire logic       low_voltage_prog,
	input wire logic       ext_reset_pin_in,
	input wire logic       reset_instr,
	input wire logic       watchdog_timeout,
	input wire logic       cpu_run,
	input wire logic       in_sleep,
	input wire logic       bor_detect_on,
	input wire logic       ext_reset_pin_out,
	input wire logic       ext_reset_pin_oe_n,
	input wire logic       gpio_in
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	AST_NO_DRIVE: assert property (ext_reset_pin_oe_n && !ext_reset_pin_out)
		else $error("reset pin driven");
	AST_PIN_HOLD: assert property (((ext_reset_pin_enable || low_voltage_prog) && !ext_reset_pin_in)[*8] |=> !cpu_run)
		else $error("pin low but running");
	AST_GPIO: assert property (!ext_reset_pin_enable && !low_voltage_prog && !$past(ext_reset_pin_enable)
		&& !$past(low_voltage_prog) |-> gpio_in == $past(ext_reset_pin_in))
		else $error("gpio input wrong");
	AST_OFF_MODE: assert property ((brownout_mode_cfg == rss_pkg::BOR_MODE_OFF)[*2] |-> !bor_detect_on)
		else $error("detector on in off mode");
	AST_ON_MODE: assert property ((brownout_mode_cfg == rss_pkg::BOR_MODE_ON)[*2] |-> bor_detect_on)
		else $error("detector off in on mode");
	AST_NOSLP: assert property (brownout_mode_cfg == rss_pkg::BOR_MODE_NOSLP && in_sleep && $past(in_sleep)
		|-> !bor_detect_on)
		else $error("detector on in sleep");
	AST_INSTR: assert property (reset_instr |-> ##[1:3] !cpu_run)
		else $error("reset instruction ignored");
	AST_WDT: assert property (watchdog_timeout |-> ##[1:3] !cpu_run)
		else $error("watchdog ignored");
endmodule

// ==== verification/rss_far_model.sv ====
`timescale 1ns/1ps
module rss_far_model
(
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic detect_on,
	input  wire logic pin_low,
	input  wire logic dip,
	input  wire logic lp_dip,
	input  wire logic stall,
	input  wire logic pin_out,
	input  wire logic pin_oe_n,
	output logic      pin,
	output logic      below_bor,
	output logic      below_low_power_brownout,
	output logic      ready
);
	logic [2:0] warm_q;
	// Weak pull-up wins when nobody drives
	assign pin = pin_low ? 1'b0 : (pin_oe_n ? 1'b1 : pin_out);
	assign below_bor = dip;
	assign below_low_power_brownout = lp_dip;
	// Detector is slow to warm up, so start-up waits really happen
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			warm_q <= 3'h0;
		else if (!detect_on)
			warm_q <= 3'h0;
		else if (warm_q != 3'h7)
			warm_q <= warm_q + 3'h1;
	end
	assign ready = (warm_q == 3'h7) && !stall;
endmodule

// ==== verification/rss_reset_source_sequencer_tb.sv ====
`timescale 1ns/1ps
module rss_reset_source_sequencer_tb;
	logic clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, low_power_brownout_en = 1'b0;
	logic ext_reset_pin_enable = 1'b1, low_voltage_prog = 1'b0, powerup_timer_enable_n = 1'b1;
	logic stack_reset_enable = 1'b0, osc_startup_needed = 1'b0, osc_startup_done = 1'b1, por_active = 1'b0;
	logic reg_wr = 1'b0, reg_rd = 1'b0, pin_low = 1'b0, dip = 1'b0, lp_dip = 1'b0, stall = 1'b0;
	logic [1:0] brownout_mode_cfg = 2'h0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00, ev = 8'h00, rv;
	int mismatches = 0, total_checks = 0, cyc = 0, n;
	wire logic sleep_req, wake_event, watchdog_timeout, watchdog_clear_instr, reset_instr, stack_overflow;
	wire logic stack_underflow, prog_mode_exit, vdd_below_bor, vdd_below_low_power_brownout, bor_circuit_ready, ext_reset_pin_in;
	wire logic core_reset_n, cpu_run, in_sleep, bor_detect_on, ext_reset_pin_out, ext_reset_pin_oe_n;
	wire logic ext_reset_pin_pullup, gpio_in;
	wire logic [7:0] reg_rdata;
	assign {prog_mode_exit, stack_underflow, stack_overflow, reset_instr} = ev[7:4];
	assign {watchdog_clear_instr, watchdog_timeout, wake_event, sleep_req} = ev[3:0];
	rss_reset_source_sequencer dut_u (.*);
	rss_far_model far_u (.clk(clk), .rst_n(rst_n), .detect_on(bor_detect_on), .pin_low(pin_low), .dip(dip),
		.lp_dip(lp_dip), .stall(stall), .pin_out(ext_reset_pin_out), .pin_oe_n(ext_reset_pin_oe_n),
		.pin(ext_reset_pin_in), .below_bor(vdd_below_bor), .below_low_power_brownout(vdd_below_low_power_brownout), .ready(bor_circuit_ready));
	always #20 clk = ~clk;
	task end_of_test;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Ceiling well above the several hundred cycles the tests need
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			mismatches++;
			end_of_test();
		end
	end
	task tk(int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task chk(string nm, logic [7:0] s, logic [7:0] e);
		total_checks++;
		if (s !== e)
		begin
			mismatches++;
			$display("MISMATCH %s exp %h seen %h", nm, e, s);
		end
	endtask
	task wr(logic [3:0] a, logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		tk(1);
		reg_wr <= 1'b0;
		tk(1);
	endtask
	task rd(logic [3:0] a);
		reg_addr <= a;
		reg_rd <= 1'b1;
		tk(1);
		reg_rd <= 1'b0;
		rv = reg_rdata;
		tk(1);
	endtask
	task pulse(int i);
		ev[i] <= 1'b1;
		tk(1);
		ev[i] <= 1'b0;
		tk(1);
	endtask
	task wait_run(logic e, int mx);
		n = 0;
		while (cpu_run !== e && n < mx)
		begin
			tk(1);
			n++;
		end
		chk("cpu_run", 8'(cpu_run), 8'(e));
	endtask
	task t_regs;
		rd(rss_pkg::ADDR_PWR_CTRL);
		chk("pwr", rv, rss_pkg::PC_RESET);
		wr(rss_pkg::ADDR_STATUS, 8'h00);
		rd(rss_pkg::ADDR_STATUS);
		chk("status", rv, 8'(rss_pkg::ST_RESET));
		rd(4'hf);
		chk("unmapped", rv, 8'h00);
		wr(rss_pkg::ADDR_BOR_CTRL, 8'h00);
		rd(rss_pkg::ADDR_BOR_CTRL);
		chk("sw_en", rv & 8'hfe, 8'h00);
	endtask
	task t_pin;
		pin_low <= 1'b1;
		tk(3);
		pin_low <= 1'b0;
		tk(3);
		chk("short", 8'(cpu_run), 8'h01);
		pin_low <= 1'b1;
		tk(20);
		chk("held", 8'(cpu_run), 8'h00);
		pin_low <= 1'b0;
		wait_run(1'b1, 40);
		chk("delay", 8'(n >= 10 && n <= 13 + rss_pkg::PIN_FILT_CYC), 8'h01);
		ext_reset_pin_enable <= 1'b0;
		pin_low <= 1'b1;
		tk(20);
		chk("gpio", {gpio_in, cpu_run}, 8'h01);
		low_voltage_prog <= 1'b1;
		tk(20);
		chk("lvp", 8'(cpu_run), 8'h00);
		{pin_low, low_voltage_prog, ext_reset_pin_enable} <= 3'h1;
		wait_run(1'b1, 40);
	endtask
	task t_src;
		int src[3] = '{2, 4, 7};
		wr(rss_pkg::ADDR_PWR_CTRL, rss_pkg::PC_RESET);
		pulse(3);
		chk("clear", 8'(cpu_run), 8'h01);
		foreach (src[i])
		begin
			pulse(src[i]);
			wait_run(1'b0, 5);
			wait_run(1'b1, 40);
		end
		rd(rss_pkg::ADDR_PWR_CTRL);
		chk("flags", rv, 8'h08);
		rd(rss_pkg::ADDR_STATUS);
		chk("timeout", rv, 8'h01);
		pulse(6);
		tk(5);
		chk("stk_off", 8'(cpu_run), 8'h01);
		stack_reset_enable <= 1'b1;
		pulse(5);
		wait_run(1'b0, 5);
		wait_run(1'b1, 40);
		rd(rss_pkg::ADDR_PWR_CTRL);
		chk("stk", rv & 8'hc0, 8'h80);
	endtask
	task t_bor;
		brownout_mode_cfg <= rss_pkg::BOR_MODE_ON;
		wr(rss_pkg::ADDR_PWR_CTRL, 8'h1f);
		tk(10);
		dip <= 1'b1;
		tk(rss_pkg::DEBOUNCE_CYC - 5);
		dip <= 1'b0;
		tk(2);
		chk("dip", 8'(cpu_run), 8'h01);
		dip <= 1'b1;
		tk(rss_pkg::DEBOUNCE_CYC + 10);
		chk("bor", 8'(cpu_run), 8'h00);
		dip <= 1'b0;
		wait_run(1'b1, 60);
		rd(rss_pkg::ADDR_PWR_CTRL);
		chk("bor_flag", rv, 8'h1e);
		pulse(0);
		chk("sleep_on", {in_sleep, bor_detect_on}, 8'h03);
		pulse(1);
		wait_run(1'b1, 20);
		brownout_mode_cfg <= rss_pkg::BOR_MODE_NOSLP;
		pulse(0);
		chk("sleep_off", {in_sleep, bor_detect_on}, 8'h02);
		stall <= 1'b1;
		pulse(1);
		tk(30);
		chk("wake_wait", 8'(cpu_run), 8'h00);
		stall <= 1'b0;
		wait_run(1'b1, 40);
		brownout_mode_cfg <= rss_pkg::BOR_MODE_SW;
		stall <= 1'b1;
		pulse(4);
		wait_run(1'b0, 5);
		wait_run(1'b1, 40);
		stall <= 1'b0;
		brownout_mode_cfg <= rss_pkg::BOR_MODE_OFF;
	endtask
	task t_lp;
		wr(rss_pkg::ADDR_PWR_CTRL, 8'h1f);
		lp_dip <= 1'b1;
		tk(40);
		chk("lp_off", 8'(cpu_run), 8'h01);
		low_power_brownout_en <= 1'b1;
		tk(40);
		chk("lp_on", 8'(cpu_run), 8'h00);
		lp_dip <= 1'b0;
		wait_run(1'b1, 60);
		rd(rss_pkg::ADDR_PWR_CTRL);
		chk("lp_flag", rv, 8'h1e);
	endtask
	task t_misc;
		chk("pullup_pin", 8'(ext_reset_pin_pullup), 8'h01);
		ext_reset_pin_enable <= 1'b0;
		wr(rss_pkg::ADDR_BOR_CTRL, 8'h00);
		tk(2);
		chk("pullup_off", 8'(ext_reset_pin_pullup), 8'h00);
		wr(rss_pkg::ADDR_BOR_CTRL, 8'h40);
		tk(2);
		chk("pullup_on", 8'(ext_reset_pin_pullup), 8'h01);
		ext_reset_pin_enable <= 1'b1;
		clk_en <= 1'b0;
		pulse(6);
		clk_en <= 1'b1;
		tk(3);
		chk("frozen", {core_reset_n, cpu_run}, 8'h03);
		por_active <= 1'b1;
		tk(5);
		chk("por_hold", {core_reset_n, cpu_run}, 8'h00);
		por_active <= 1'b0;
		wait_run(1'b1, 40);
		rd(rss_pkg::ADDR_PWR_CTRL);
		chk("por_flag", rv & 8'h02, 8'h00);
	endtask
	initial
	begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		wait_run(1'b1, 100);
		t_regs();
		t_pin();
		t_src();
		t_bor();
		t_lp();
		t_misc();
		end_of_test();
	end
endmodule
bind rss_reset_source_sequencer rss_checker chk_u (.*);
